/* common/acem_pkg.sv */
package acem_pkg;

   // ****************************************
   // sizes and defaults
   // ****************************************
   localparam int PORT_W = 5;
   localparam int COUNT_W = 32;
   localparam int NUM_ENTRIES_DEF = 512;
   localparam int NUM_RESERVED_DEF = 2;
   localparam int APB_AW = 12;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] OFS_INDEX = 8'h00;
   localparam logic [7:0] OFS_CFG0 = 8'h04;
   localparam logic [7:0] OFS_CFG1 = 8'h08;
   localparam logic [7:0] OFS_SOURCE_ADDRESS_FILTER_LO = 8'h0c;
   localparam logic [7:0] OFS_SOURCE_ADDRESS_FILTER_HI = 8'h10;
   localparam logic [7:0] OFS_DESTINATION_ADDRESS_FILTER_LO = 8'h14;
   localparam logic [7:0] OFS_DESTINATION_ADDRESS_FILTER_HI = 8'h18;
   localparam logic [7:0] OFS_CMD = 8'h1c;
   localparam logic [7:0] OFS_COUNT = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;

   // ****************************************
   // frame limits and codes
   // ****************************************
   localparam logic [15:0] ETYPE_MIN = 16'h0600;
   localparam logic [15:0] LEN_LIMIT = 16'h05ee;
   localparam logic [4:0] RATE_OFF = 5'h00;
   localparam logic [4:0] RATE_MAX = 5'h10;
   localparam logic [47:0] MAC_BCAST = 48'hffffffffffff;
   localparam int MAC_GROUP_BIT = 40;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      FT_ANY, FT_ETYPE, FT_ARP, FT_IPV4, FT_IPV6
   } acem_ftype_t;

   typedef enum logic [2:0] {
      DM_ANY, DM_MCAST, DM_BCAST, DM_UCAST, DM_SPEC
   } acem_dmode_t;

   typedef struct packed {
      logic [3:0] rsvd;
      logic valid;
      acem_ftype_t ftype;
      logic deny;
      logic policy_spec;
      logic [7:0] policy_mask;
      logic [7:0] policy_val;
      logic port_any;
      logic [PORT_W-1:0] port_num;
   } acem_cfg0_t;

   typedef struct packed {
      logic [13:0] rsvd;
      acem_dmode_t dmode;
      logic source_address_filter_spec;
      logic shutdown;
      logic log_en;
      logic mirror;
      logic redir_en;
      logic [PORT_W-1:0] redir_port;
      logic [4:0] rate_lim;
   } acem_cfg1_t;

   typedef struct packed {
      acem_cfg0_t c0;
      acem_cfg1_t c1;
      logic [47:0] source_address_filter;
      logic [47:0] destination_address_filter;
   } acem_entry_t;

   typedef struct packed {
      logic [28:0] rsvd;
      logic clr_count;
      logic fetch;
      logic commit;
   } acem_cmd_t;

   typedef struct packed {
      logic busy;
      logic last_hit;
      logic [13:0] rsvd;
      logic [15:0] last_idx;
   } acem_status_t;

   typedef struct packed {
      logic [PORT_W-1:0] port;
      logic [7:0] policy;
      logic [15:0] ethertype;
      logic is_arp;
      logic is_ipv4;
      logic is_ipv6;
      logic [47:0] source_address_filter;
      logic [47:0] destination_address_filter;
      logic [15:0] length;
   } acem_frame_t;

   typedef struct packed {
      logic hit;
      logic [15:0] hit_idx;
      logic drop;
      logic [4:0] rate_lim;
      logic redir_en;
      logic [PORT_W-1:0] redir_port;
      logic mirror;
      logic log_en;
      logic shutdown;
      logic [PORT_W-1:0] shut_port;
   } acem_result_t;

endpackage

/* rtl/acem_matcher.sv */
// Function
// - hit only when every configured filter holds; don't-care filters pass
// - ingress selector is any port or one specific port number
// - specific policy compares value under 8-bit mask, else ignored
// - frame type is any, ethernet type, arp, ipv4 or ipv6
// - ethernet type class needs length/type at least 0x0600
// - arp frames never hit an ethernet type entry
// - ipv4 and ipv6 frames never hit an ethernet type entry
// - deny drops the hitting frame, permit lets it continue
// - entry names limiter 1 to 16 or disables limiting
// - redirect sends frame to given port, disabled leaves forwarding
// - mirror copies hitting frames, off after defaults
// - mirror copies are not policed by the entry limiter
// - logging reported only for frames shorter than 1518 bytes
// - shutdown disables ingress port only for frames below 1518 bytes
// - each entry hit counter counts once per hitting frame
// - source filter only for ethernet type and arp entries
// - destination filter may demand multicast, broadcast or unicast
// - specific destination filter needs exact 48-bit address
// - table holds up to 512 entries
// - reserved entries are searched first, ahead of user entries
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/10ps
module acem_matcher #(
   parameter int NUM_ENTRIES = acem_pkg::NUM_ENTRIES_DEF,
   parameter int NUM_RESERVED = acem_pkg::NUM_RESERVED_DEF
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [acem_pkg::APB_AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // parsed frame in
   input wire logic frame_valid_i,
   input wire acem_pkg::acem_frame_t frame_i,
   output logic frame_ready_o,
   // classification out
   output logic result_valid_o,
   output acem_pkg::acem_result_t result_o
);
   import acem_pkg::*;

   // ****************************************
   // types and storage
   // ****************************************
   localparam int IDX_W = (NUM_ENTRIES > 1) ? $clog2(NUM_ENTRIES) : 1;
   localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(NUM_ENTRIES - 1);

   typedef enum {ST_IDLE, ST_SCAN} acem_fsm_t;

   typedef struct packed {
      acem_fsm_t fsm;
      logic [IDX_W-1:0] scan_idx;
      logic [IDX_W-1:0] sel_idx;
      acem_frame_t frame;
      acem_entry_t stage;
      acem_result_t result;
      logic res_valid;
      logic last_hit;
      logic [IDX_W-1:0] last_idx;
   } acem_st_t;

   acem_st_t st_reg;
   acem_st_t st_next;

   // entry table, valid flags and hit counters
   acem_entry_t table_mem [NUM_ENTRIES];
   logic [NUM_ENTRIES-1:0] valid_reg;
   logic [COUNT_W-1:0] count_mem [NUM_ENTRIES];

   acem_entry_t cur;
   logic cur_hit;
   logic wr_en;
   logic rd_en;
   logic mapped;
   logic commit_en;
   logic clr_en;
   logic inc_en;
   logic cmd_wr;
   logic fetch_en;
   logic idx_ok;
   logic len_ok;
   acem_cmd_t cmd;
   acem_status_t status;

   // ****************************************
   // ingress port and policy filters
   // ****************************************
   function automatic logic port_match(acem_entry_t e, acem_frame_t f);
      port_match = e.c0.port_any || (f.port == e.c0.port_num);
   endfunction

   function automatic logic policy_match(acem_entry_t e, acem_frame_t f);
      policy_match = !e.c0.policy_spec ||
         ((f.policy & e.c0.policy_mask) ==
          (e.c0.policy_val & e.c0.policy_mask));
   endfunction

   // ****************************************
   // frame class filter
   // ****************************************
   function automatic logic class_match(acem_entry_t e, acem_frame_t f);
      logic etype_cls;
      etype_cls = (f.ethertype >= ETYPE_MIN) && !f.is_arp &&
         !f.is_ipv4 && !f.is_ipv6;
      unique case (e.c0.ftype)
         FT_ANY: class_match = 1'b1;
         FT_ETYPE: class_match = etype_cls;
         FT_ARP: class_match = f.is_arp;
         FT_IPV4: class_match = f.is_ipv4;
         FT_IPV6: class_match = f.is_ipv6;
         default: class_match = 1'b0;
      endcase
   endfunction

   // ****************************************
   // address filters
   // ****************************************
   function automatic logic source_match(acem_entry_t e, acem_frame_t f);
      // source filter for etype and arp
      source_match = !(e.c0.ftype inside {FT_ETYPE, FT_ARP}) ||
         !e.c1.source_address_filter_spec || (f.source_address_filter == e.source_address_filter);
   endfunction

   function automatic logic dest_match(acem_entry_t e, acem_frame_t f);
      logic bcast;
      logic group;
      bcast = (f.destination_address_filter == MAC_BCAST);
      group = f.destination_address_filter[MAC_GROUP_BIT];
      unique case (e.c1.dmode)
         DM_ANY: dest_match = 1'b1;
         DM_MCAST: dest_match = group && !bcast;
         DM_BCAST: dest_match = bcast;
         DM_UCAST: dest_match = !group;
         DM_SPEC: dest_match = (f.destination_address_filter == e.destination_address_filter);
         default: dest_match = 1'b0;
      endcase
   endfunction

   // ****************************************
   // match of one entry against one frame
   // ****************************************
   function automatic logic entry_hit(acem_entry_t e, acem_frame_t f);
      entry_hit = port_match(e, f) && policy_match(e, f) &&
         class_match(e, f) && source_match(e, f) && dest_match(e, f);
   endfunction

   // ****************************************
   // apb decode
   // ****************************************
   assign wr_en = psel_i && penable_i && pwrite_i && mapped;
   assign rd_en = psel_i && penable_i && !pwrite_i;
   assign cmd = acem_cmd_t'(pwdata_i);
   assign cmd_wr = wr_en && (paddr_i[7:0] == OFS_CMD);
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !mapped;

   // ****************************************
   // index range guard
   // ****************************************
   // an index past the table end never reaches the arrays
   assign idx_ok = (st_reg.sel_idx <= LAST_IDX);
   assign commit_en = cmd_wr && cmd.commit && idx_ok;
   assign fetch_en = cmd_wr && cmd.fetch && idx_ok;
   assign clr_en = cmd_wr && cmd.clr_count && idx_ok;

   always_comb begin
      mapped = 1'b0;
      if ((paddr_i[APB_AW-1:8] == '0) && (paddr_i[1:0] == 2'h0)) begin
         unique case (paddr_i[7:0])
            OFS_INDEX, OFS_CFG0, OFS_CFG1, OFS_SOURCE_ADDRESS_FILTER_LO, OFS_SOURCE_ADDRESS_FILTER_HI,
            OFS_DESTINATION_ADDRESS_FILTER_LO, OFS_DESTINATION_ADDRESS_FILTER_HI, OFS_CMD, OFS_COUNT,
            OFS_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
         endcase
      end
   end

   // ****************************************
   // register read data
   // ****************************************
   // busy and last outcome
   always_comb begin
      status = '0;
      status.busy = (st_reg.fsm == ST_SCAN);
      status.last_hit = st_reg.last_hit;
      status.last_idx = 16'(st_reg.last_idx);
   end

   always_comb begin
      prdata_o = 32'h00000000;
      if (rd_en && mapped) begin
         unique case (paddr_i[7:0])
            OFS_INDEX: prdata_o = 32'(st_reg.sel_idx);
            OFS_CFG0: prdata_o = 32'(st_reg.stage.c0);
            OFS_CFG1: prdata_o = 32'(st_reg.stage.c1);
            OFS_SOURCE_ADDRESS_FILTER_LO: prdata_o = st_reg.stage.source_address_filter[31:0];
            OFS_SOURCE_ADDRESS_FILTER_HI: prdata_o = {16'h0000, st_reg.stage.source_address_filter[47:32]};
            OFS_DESTINATION_ADDRESS_FILTER_LO: prdata_o = st_reg.stage.destination_address_filter[31:0];
            OFS_DESTINATION_ADDRESS_FILTER_HI: prdata_o = {16'h0000, st_reg.stage.destination_address_filter[47:32]};
            OFS_COUNT: prdata_o = idx_ok ?
               32'(count_mem[st_reg.sel_idx]) : 32'h00000000;
            OFS_STATUS: prdata_o = 32'(status);
            default: prdata_o = 32'h00000000;
         endcase
      end
   end

   // ****************************************
   // scan and staging logic
   // ****************************************
   assign cur = table_mem[st_reg.scan_idx];
   assign cur_hit = valid_reg[st_reg.scan_idx] && entry_hit(cur, st_reg.frame);
   assign inc_en = (st_reg.fsm == ST_SCAN) && cur_hit;
   assign len_ok = (st_reg.frame.length < LEN_LIMIT);

   // ****************************************
   // handshake and result outputs
   // ****************************************
   assign frame_ready_o = (st_reg.fsm == ST_IDLE);
   assign result_valid_o = st_reg.res_valid;
   assign result_o = st_reg.result;

   // ****************************************
   // next state
   // ****************************************
   // bus writes first, then the scan step
   always_comb begin
      st_next = st_reg;
      st_next.res_valid = 1'b0;
      if (wr_en) begin
         unique case (paddr_i[7:0])
            OFS_INDEX: st_next.sel_idx = pwdata_i[IDX_W-1:0];
            OFS_CFG0: st_next.stage.c0 = acem_cfg0_t'(pwdata_i);
            OFS_CFG1: st_next.stage.c1 = acem_cfg1_t'(pwdata_i);
            OFS_SOURCE_ADDRESS_FILTER_LO: st_next.stage.source_address_filter[31:0] = pwdata_i;
            OFS_SOURCE_ADDRESS_FILTER_HI: st_next.stage.source_address_filter[47:32] = pwdata_i[15:0];
            OFS_DESTINATION_ADDRESS_FILTER_LO: st_next.stage.destination_address_filter[31:0] = pwdata_i;
            OFS_DESTINATION_ADDRESS_FILTER_HI: st_next.stage.destination_address_filter[47:32] = pwdata_i[15:0];
            OFS_CMD: begin
               if (fetch_en) begin
                  st_next.stage = table_mem[st_reg.sel_idx];
                  st_next.stage.c0.valid = valid_reg[st_reg.sel_idx];
               end
            end
            default: st_next.sel_idx = st_reg.sel_idx;
         endcase
      end
      unique case (st_reg.fsm)
         ST_IDLE: begin
            if (frame_valid_i) begin
               st_next.frame = frame_i;
               st_next.scan_idx = '0;
               st_next.fsm = ST_SCAN;
            end
         end
         ST_SCAN: begin
            if (cur_hit) begin
               st_next.fsm = ST_IDLE;
               st_next.res_valid = 1'b1;
               st_next.last_hit = 1'b1;
               st_next.last_idx = st_reg.scan_idx;
               st_next.result.hit = 1'b1;
               st_next.result.hit_idx = 16'(st_reg.scan_idx);
               st_next.result.drop = cur.c0.deny;
               st_next.result.rate_lim = (cur.c1.rate_lim > RATE_MAX) ?
                  RATE_OFF : cur.c1.rate_lim;
               st_next.result.redir_en = cur.c1.redir_en;
               st_next.result.redir_port = cur.c1.redir_port;
               st_next.result.mirror = cur.c1.mirror;
               st_next.result.log_en = cur.c1.log_en && len_ok;
               st_next.result.shutdown = cur.c1.shutdown && len_ok;
               st_next.result.shut_port = st_reg.frame.port;
            end else if (st_reg.scan_idx == LAST_IDX) begin
               st_next.fsm = ST_IDLE;
               st_next.res_valid = 1'b1;
               st_next.last_hit = 1'b0;
               st_next.result = '0;
            end else begin
               st_next.scan_idx = st_reg.scan_idx + 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // entry table
   // ****************************************
   // entry storage
   // commit copies the staging words
   always_ff @(posedge clk_i) begin
      if (commit_en) begin
         table_mem[st_reg.sel_idx] <= st_reg.stage;
      end
   end

   // ****************************************
   // valid flags
   // ****************************************
   // flags reset so no stale entry can hit
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         valid_reg <= '0;
      end else if (commit_en) begin
         valid_reg[st_reg.sel_idx] <= st_reg.stage.c0.valid;
      end
   end

   // ****************************************
   // hit counters
   // ****************************************
   // a hit on the cleared entry in the clear cycle restarts its count at 1
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < NUM_ENTRIES; i++) begin
            count_mem[i] <= '0;
         end
      end else begin
         if (clr_en && !(inc_en && (st_reg.scan_idx == st_reg.sel_idx))) begin
            count_mem[st_reg.sel_idx] <= '0;
         end
         if (inc_en) begin
            if (clr_en && (st_reg.scan_idx == st_reg.sel_idx)) begin
               count_mem[st_reg.scan_idx] <= COUNT_W'(1);
            end else begin
               count_mem[st_reg.scan_idx] <=
                  count_mem[st_reg.scan_idx] + 1'b1;
            end
         end
      end
   end

endmodule

/* verification/acem_matcher_props.sv */
`timescale 1ns/10ps
module acem_matcher_props #(
   parameter int NUM_ENTRIES = acem_pkg::NUM_ENTRIES_DEF,
   parameter int NUM_RESERVED = acem_pkg::NUM_RESERVED_DEF
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [acem_pkg::APB_AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // frames
   input wire logic frame_valid_i,
   input wire acem_pkg::acem_frame_t frame_i,
   input wire logic frame_ready_o,
   input wire logic result_valid_o,
   input wire acem_pkg::acem_result_t result_o
);
   import acem_pkg::*;
   localparam int SCAN_MAX = NUM_ENTRIES + 1;
   logic [15:0] len_q;
   logic [PORT_W-1:0] port_q;

   // ****************************************
   // frame capture and checks
   // ****************************************
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         len_q <= 16'h0;
         port_q <= '0;
      end else if (frame_valid_i && frame_ready_o) begin
         len_q <= frame_i.length;
         port_q <= frame_i.port;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   sequence take_s;
      frame_valid_i && frame_ready_o;
   endsequence
   sequence done_s;
      result_valid_o;
   endsequence

   scan_bound_a: assert property (take_s |-> ##[2:SCAN_MAX] done_s)
      else $error("no result within the scan time");
   busy_scan_a: assert property (take_s |=> !frame_ready_o)
      else $error("frame taken while scanning");
   ready_back_a: assert property ($rose(frame_ready_o) |-> done_s)
      else $error("ready returned without a result");
   pulse_once_a: assert property (done_s |=> !result_valid_o)
      else $error("result pulse longer than one cycle");
   miss_zero_a: assert property (
      result_valid_o && !result_o.hit |-> result_o == '0)
      else $error("action reported without a hit");
   drop_hit_a: assert property (
      result_valid_o && result_o.drop |-> result_o.hit)
      else $error("drop without a hit");
   fwd_hit_a: assert property (
      result_valid_o && (result_o.redir_en || result_o.mirror) |->
      result_o.hit)
      else $error("redirect or mirror without a hit");
   rate_range_a: assert property (
      result_valid_o |-> result_o.rate_lim <= RATE_MAX)
      else $error("limiter number out of range");
   hit_index_a: assert property (
      result_valid_o && result_o.hit |-> result_o.hit_idx < NUM_ENTRIES)
      else $error("hit index beyond the table");
   log_len_a: assert property (
      result_valid_o && result_o.log_en |-> len_q < LEN_LIMIT)
      else $error("log on a long frame");
   shut_len_a: assert property (
      result_valid_o && result_o.shutdown |->
      len_q < LEN_LIMIT && result_o.shut_port == port_q)
      else $error("shutdown on a long frame or wrong port");
endmodule

bind acem_matcher acem_matcher_props #(
   .NUM_ENTRIES(NUM_ENTRIES),
   .NUM_RESERVED(NUM_RESERVED)
) i_props (
   .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .frame_valid_i(frame_valid_i),
   .frame_i(frame_i), .frame_ready_o(frame_ready_o),
   .result_valid_o(result_valid_o), .result_o(result_o)
);

/* verification/acem_parser_model.sv */
`timescale 1ns/10ps
module acem_parser_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // request from bench
   input wire logic send_i,
   input wire acem_pkg::acem_frame_t frame_i,
   // frame handshake
   input wire logic frame_ready_i,
   output logic frame_valid_o,
   output acem_pkg::acem_frame_t frame_o
);
   import acem_pkg::*;

   // ****************************************
   // offer held until taken, then scrambled
   // ****************************************
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         frame_valid_o <= 1'h0;
         frame_o <= '0;
      end else if (frame_valid_o && frame_ready_i) begin
         frame_valid_o <= 1'h0;
         frame_o <= ~frame_o;
      end else if (send_i && !frame_valid_o) begin
         frame_valid_o <= 1'h1;
         frame_o <= frame_i;
      end
   end
endmodule

/* verification/tb_acem_matcher.sv */
`timescale 1ns/10ps
module tb_acem_matcher;
   import acem_pkg::*;
   logic clk_i = 1'h0;
   logic reset_n_i = 1'h1;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, send = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic pready, pslverr, rerr, fvalid, fready, rvalid;
   logic [2:0] act, hits_a;
   logic [4:0] hits_b;
   logic [23:0] pr;
   acem_frame_t frm = '0, ffar, f0, f;
   acem_result_t result, res;
   logic [47:0] sm = 48'h0a0b0c0d0e0f, dm = 48'h020304050607;
   acem_ftype_t fts[3] = '{FT_ARP, FT_IPV4, FT_IPV6};
   acem_dmode_t dms[3] = '{DM_MCAST, DM_UCAST, DM_BCAST};
   logic [47:0] macs[3] = '{48'h01005e000001, 48'h020000000001,
      48'hffffffffffff};
   int num_errors = 0, checks = 0;

   acem_matcher #(.NUM_ENTRIES(8), .NUM_RESERVED(2)) i_dut (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .frame_valid_i(fvalid), .frame_i(ffar),
      .frame_ready_o(fready), .result_valid_o(rvalid), .result_o(result));
   acem_parser_model i_far (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .send_i(send), .frame_i(frm), .frame_ready_i(fready),
      .frame_valid_o(fvalid), .frame_o(ffar));

   initial begin
      forever #50 clk_i = ~clk_i;
   end

   // ****************************************
   // bench tasks
   // ****************************************
   task automatic check(input string nm, input logic [63:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run;
      if (num_errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic timeout;
      num_errors++;
      complete_run();
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {4'h0, a};
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (pready !== 1'h1) timeout();
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk_i);
   endtask
   task automatic set_entry(input logic [15:0] ix, input logic [31:0] c0, c1);
      apb(1'h1, OFS_INDEX, {16'h0, ix});
      apb(1'h1, OFS_CFG0, c0);
      apb(1'h1, OFS_CFG1, c1);
      apb(1'h1, OFS_SOURCE_ADDRESS_FILTER_LO, sm[31:0]);
      apb(1'h1, OFS_SOURCE_ADDRESS_FILTER_HI, {16'h0, sm[47:32]});
      apb(1'h1, OFS_DESTINATION_ADDRESS_FILTER_LO, dm[31:0]);
      apb(1'h1, OFS_DESTINATION_ADDRESS_FILTER_HI, {16'h0, dm[47:32]});
      apb(1'h1, OFS_CMD, 32'h1);
   endtask
   task automatic send_frame(input acem_frame_t fr);
      int n;
      frm <= fr;
      send <= 1'h1;
      @(posedge clk_i);
      send <= 1'h0;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (rvalid !== 1'h1 && n < 40);
      if (rvalid !== 1'h1) timeout();
      res = result;
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      reset_n_i = 1'h0;
      f0 = '0;
      f0.port = 5'h05;
      f0.policy = 8'ha5;
      f0.ethertype = 16'h88b5;
      f0.source_address_filter = sm;
      f0.destination_address_filter = dm;
      f0.length = 16'h0040;
      repeat (20) @(posedge clk_i);
      reset_n_i <= 1'h1;
      send_frame(f0);
      check("empty", 64'(res), 64'h0);
      apb(1'h0, 8'h28, 32'h0);
      check("unmapped", 64'({rerr, rdata}), 64'h100000000);
      set_entry(16'h0003,
         {4'h0, 1'h1, FT_ETYPE, 1'h1, 1'h1, 8'hf0, 8'ha5, 1'h0, 5'h05},
         {14'h0, DM_SPEC, 5'h1f, 5'h07, 5'h10});
      send_frame(f0);
      check("full", 64'(res), 64'({1'h1, 16'h0003, 1'h1, 5'h10, 1'h1, 5'h07,
         3'h7, 5'h05}));
      apb(1'h0, OFS_COUNT, 32'h0);
      check("count", 64'(rdata), 64'h1);
      for (int i = 0; i < 8; i++) begin
         f = f0;
         case (i)
            0: f.port = 5'h04;
            1: f.policy = 8'hb5;
            2: f.ethertype = 16'h05ff;
            3: f.is_arp = 1'h1;
            4: f.is_ipv4 = 1'h1;
            5: f.is_ipv6 = 1'h1;
            6: f.source_address_filter[0] = 1'h0;
            default: f.destination_address_filter[0] = 1'h0;
         endcase
         send_frame(f);
         if (i < 3) hits_a[i] = res.hit;
         else hits_b[i-3] = res.hit;
      end
      check("miss1", 64'(hits_a), 64'h0);
      check("miss2", 64'(hits_b), 64'h0);
      f = f0;
      f.policy = 8'haf;
      f.length = 16'h05ee;
      send_frame(f);
      act = {res.hit, res.log_en, res.shutdown};
      check("at1518", 64'(act), 64'h4);
      f.length = 16'h05ed;
      send_frame(f);
      act = {res.hit, res.log_en, res.shutdown};
      check("at1517", 64'(act), 64'h7);
      set_entry(16'h0001, {4'h0, 1'h1, FT_ANY, 18'h0, 1'h1, 5'h00}, 32'h0);
      send_frame(f0);
      pr = {res.hit, res.hit_idx, res.drop, res.rate_lim, res.mirror};
      check("prio", 64'(pr), 64'({1'h1, 16'h0001, 7'h00}));
      apb(1'h1, OFS_INDEX, 32'h3);
      apb(1'h0, OFS_COUNT, 32'h0);
      check("count3", 64'(rdata), 64'h3);
      for (int i = 0; i < 3; i++) begin
         set_entry(16'h0000, {4'h0, 1'h1, fts[i], 18'h0, 1'h1, 5'h00},
            {14'h0, dms[i], 15'h0});
         f = f0;
         {f.is_arp, f.is_ipv4, f.is_ipv6} = 3'h4 >> i;
         f.destination_address_filter = macs[i];
         send_frame(f);
         check("cls", 64'({res.hit, res.hit_idx}), 64'h10000);
         f.destination_address_filter = macs[(i+1)%3];
         send_frame(f);
         check("cls", 64'({res.hit, res.hit_idx}), 64'h10001);
      end
      apb(1'h0, OFS_STATUS, 32'h0);
      check("status", 64'(rdata), 64'h40000001);
      apb(1'h1, OFS_INDEX, 32'h3);
      apb(1'h1, OFS_CMD, 32'h2);
      apb(1'h0, OFS_CFG0, 32'h0);
      check("fetch0", 64'(rdata), 64'h09fc2945);
      apb(1'h0, OFS_CFG1, 32'h0);
      check("fetch1", 64'(rdata), 64'h00027cf0);
      apb(1'h1, OFS_CMD, 32'h4);
      apb(1'h0, OFS_COUNT, 32'h0);
      check("clear", 64'(rdata), 64'h0);
      complete_run();
   end
endmodule
